// [rtl/dasc_pin_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
`default_nettype none

module dasc_pin_sync #(
  parameter int unsigned W = 1
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  // pins in, filtered out
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ==========================================================
  // flop chain
  always_ff @(posedge clk) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else if (ce) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ==========================================================
  // accept a bit once stages two and three agree
  always_ff @(posedge clk) begin
    if (reset) begin
      dout <= '0;
    end else if (ce) begin
      dout <= (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
    end
  end

endmodule // dasc_pin_sync

`default_nettype wire

// [rtl/dasc_pkg.sv]
// constants, types and helpers shared by the attenuator state control
package dasc_pkg;

  // ==========================================================
  // word layout
  localparam int unsigned WORD_W     = 56;
  localparam int unsigned STATE_W    = 5;
  localparam int unsigned NUM_STATES = 4;
  localparam int unsigned FIELD_W    = STATE_W * NUM_STATES;
  localparam int unsigned ATT1_BASE  = 8;
  localparam int unsigned ATT2_BASE  = 36;
  localparam logic [55:0] WORD_KEEP_MASK = 56'hFFFFF00FFFFF00;
  localparam logic [55:0] WORD_RESET     = 56'h00000000000000;

  // ==========================================================
  // apb map
  localparam logic [7:0] OFS_WORD_LO = 8'h00;
  localparam logic [7:0] OFS_WORD_HI = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam int unsigned HI_W       = WORD_W - 32;
  localparam int unsigned ST_ATT1_LSB = 0;
  localparam int unsigned ST_ATT2_LSB = 8;
  localparam int unsigned ST_MODE_BIT = 16;
  localparam logic [31:0] RDATA_RESET = 32'h00000000;

  // ==========================================================
  // pin carrier
  typedef struct packed {
    logic                  mode;
    logic [1:0]            sel1;
    logic [1:0]            sel2;
    logic [STATE_W-1:0]    dir1;
    logic [STATE_W-1:0]    dir2;
  } dasc_pins_t;

  localparam int unsigned PINS_W = $bits(dasc_pins_t);

  typedef struct packed {
    logic [STATE_W-1:0] att1;
    logic [STATE_W-1:0] att2;
  } dasc_applied_t;

  // ==========================================================
  // helpers
  function automatic logic [FIELD_W-1:0] stateBank(input logic [WORD_W-1:0] w,
                                                   input int unsigned base);
    stateBank = w[base +: FIELD_W];
  endfunction

  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    mergeBytes = r;
  endfunction

endpackage

// [rtl/dasc_state_pick.sv]
// picks one of four stored five-bit states by a two-pin select
`timescale 1ns/10ps
`default_nettype none

module dasc_state_pick (
  // stored states, state one lowest
  input  wire logic [dasc_pkg::FIELD_W-1:0] bank,
  // select pins: bit 0 low pin, bit 1 high pin
  input  wire logic [1:0]                   sel,
  // chosen state
  output var  logic [dasc_pkg::STATE_W-1:0] state
);

  // ==========================================================
  // index {high, low}: 00 s1, 01 s2, 10 s3, 11 s4
  always_comb begin
    case (sel)
      2'h0:    state = bank[0*dasc_pkg::STATE_W +: dasc_pkg::STATE_W];
      2'h1:    state = bank[1*dasc_pkg::STATE_W +: dasc_pkg::STATE_W];
      2'h2:    state = bank[2*dasc_pkg::STATE_W +: dasc_pkg::STATE_W];
      2'h3:    state = bank[3*dasc_pkg::STATE_W +: dasc_pkg::STATE_W];
      default: state = '0;
    endcase
  end

endmodule // dasc_state_pick

`default_nettype wire

// [rtl/dasc_top.sv]
// dual attenuator state control: apb word store, pin sync, state apply
//
// Contract
// - word bits 12..8 are attenuator one state one
// - mode low: attenuators follow direct weight inputs
// - stored mode: drive applied levels onto direct pins
// - attenuator one selects state by its pin pair
// - attenuator two selects state, same encoding
// - attenuator one states in word bits 8..27
// - attenuator two states in word bits 36..55
// - 56-bit word, field top bit weighs 16 dB
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module dasc_top (
  // clock, reset, enable
  input  wire logic                         clk,
  input  wire logic                         reset,
  input  wire logic                         ce,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [7:0]                   paddr,
  input  wire logic [31:0]                  pwdata,
  input  wire logic [3:0]                   pstrb,
  output var  logic [31:0]                  prdata,
  output var  logic                         pready,
  output var  logic                         pslverr,
  // mode and state select pins
  input  wire logic                         source_mode_select,
  input  wire logic                         att1_state_sel_low,
  input  wire logic                         att1_state_sel_high,
  input  wire logic                         att2_state_sel_low,
  input  wire logic                         att2_state_sel_high,
  // direct weight pins, attenuator one
  input  wire logic [dasc_pkg::STATE_W-1:0] direct_weight_inputs1_in,
  output var  logic [dasc_pkg::STATE_W-1:0] direct_weight_inputs1_out,
  output var  logic [dasc_pkg::STATE_W-1:0] direct_weight_inputs1_oe,
  // direct weight pins, attenuator two
  input  wire logic [dasc_pkg::STATE_W-1:0] direct_weight_inputs2_in,
  output var  logic [dasc_pkg::STATE_W-1:0] direct_weight_inputs2_out,
  output var  logic [dasc_pkg::STATE_W-1:0] direct_weight_inputs2_oe,
  // attenuator stage controls, bit 4 = 16 dB
  output var  logic [dasc_pkg::STATE_W-1:0] att1Ctrl,
  output var  logic [dasc_pkg::STATE_W-1:0] att2Ctrl
);

  logic [dasc_pkg::WORD_W-1:0]  word;
  dasc_pkg::dasc_pins_t         rawPins;
  dasc_pkg::dasc_pins_t         pins;
  logic [dasc_pkg::STATE_W-1:0] pick1;
  logic [dasc_pkg::STATE_W-1:0] pick2;
  logic [dasc_pkg::STATE_W-1:0] next_att1;
  logic [dasc_pkg::STATE_W-1:0] next_att2;
  logic                         waitDone;
  logic                         access;
  logic                         hitLo;
  logic                         hitHi;
  logic                         hitSt;
  logic [31:0]                  wordLoView;
  logic [31:0]                  wordHiView;
  logic [31:0]                  hiMerged;

  // ==========================================================
  // pin synchronisers
  always_comb begin
    rawPins.mode = source_mode_select;
    rawPins.sel1 = {att1_state_sel_high, att1_state_sel_low};
    rawPins.sel2 = {att2_state_sel_high, att2_state_sel_low};
    rawPins.dir1 = direct_weight_inputs1_in;
    rawPins.dir2 = direct_weight_inputs2_in;
  end

  dasc_pin_sync #(
    .W (dasc_pkg::PINS_W)
  ) u_sync (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .din   (rawPins),
    .dout  (pins)
  );

  // ==========================================================
  // state selection
  // bank one fields
  dasc_state_pick u_pick1 (
    .bank  (dasc_pkg::stateBank(word, dasc_pkg::ATT1_BASE)),
    .sel   (pins.sel1),
    .state (pick1)
  );

  dasc_state_pick u_pick2 (
    .bank  (dasc_pkg::stateBank(word, dasc_pkg::ATT2_BASE)),
    .sel   (pins.sel2),
    .state (pick2)
  );

  // ==========================================================
  // source mux
  always_comb begin
    next_att1 = pins.dir1;
    next_att2 = pins.dir2;
    if (pins.mode) begin
      next_att1 = pick1;
      next_att2 = pick2;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      att1Ctrl <= '0;
      att2Ctrl <= '0;
    end else if (ce) begin
      att1Ctrl <= next_att1;
      att2Ctrl <= next_att2;
    end
  end

  // ==========================================================
  // direct pin readback drive
  // drive applied levels in stored mode
  always_ff @(posedge clk) begin
    if (reset) begin
      direct_weight_inputs1_out <= '0;
      direct_weight_inputs2_out <= '0;
      direct_weight_inputs1_oe  <= '0;
      direct_weight_inputs2_oe  <= '0;
    end else if (ce) begin
      direct_weight_inputs1_out <= next_att1;
      direct_weight_inputs2_out <= next_att2;
      direct_weight_inputs1_oe  <= {dasc_pkg::STATE_W{pins.mode}};
      direct_weight_inputs2_oe  <= {dasc_pkg::STATE_W{pins.mode}};
    end
  end

  // ==========================================================
  // apb decode, one wait state
  assign access = psel && penable;
  assign hitLo  = (paddr == dasc_pkg::OFS_WORD_LO);
  assign hitHi  = (paddr == dasc_pkg::OFS_WORD_HI);
  assign hitSt  = (paddr == dasc_pkg::OFS_STATUS);
  assign pready = waitDone && access;

  // word views, reserved bits read zero
  assign wordLoView = word[31:0] & dasc_pkg::WORD_KEEP_MASK[31:0];
  assign wordHiView = {8'h00, word[55:32] & dasc_pkg::WORD_KEEP_MASK[55:32]};
  assign hiMerged   = dasc_pkg::mergeBytes(wordHiView, pwdata, pstrb);

  always_ff @(posedge clk) begin
    if (reset) begin
      waitDone <= 1'b0;
    end else if (ce) begin
      waitDone <= access && !waitDone;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prdata  <= dasc_pkg::RDATA_RESET;
      pslverr <= 1'b0;
    end else if (ce && access && !waitDone) begin
      pslverr <= !(hitLo || hitHi || hitSt);
      prdata  <= dasc_pkg::RDATA_RESET;
      if (!pwrite) begin
        if (hitLo) begin
          prdata <= wordLoView;
        end else if (hitHi) begin
          prdata <= wordHiView;
        end else if (hitSt) begin
          prdata[dasc_pkg::ST_ATT1_LSB +: dasc_pkg::STATE_W] <= att1Ctrl;
          prdata[dasc_pkg::ST_ATT2_LSB +: dasc_pkg::STATE_W] <= att2Ctrl;
          prdata[dasc_pkg::ST_MODE_BIT]                      <= pins.mode;
        end
      end
    end
  end

  // ==========================================================
  // word store
  // word fields fixed by position
  always_ff @(posedge clk) begin
    if (reset) begin
      word <= dasc_pkg::WORD_RESET;
    end else if (ce && pready && pwrite) begin
      if (hitLo) begin
        word[31:0] <= dasc_pkg::mergeBytes(word[31:0], pwdata, pstrb)
                      & dasc_pkg::WORD_KEEP_MASK[31:0];
      end else if (hitHi) begin
        word[55:32] <= hiMerged[dasc_pkg::HI_W-1:0]
                       & dasc_pkg::WORD_KEEP_MASK[55:32];
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence modeHighStep;
    ce && pins.mode;
  endsequence

  sequence modeLowStep;
    ce && !pins.mode;
  endsequence

  sequence apbSetup;
    ce && psel && !penable;
  endsequence

  sequence apbFirstAccess;
    ce && access;
  endsequence

  sequence firstRead;
    ce && access && !waitDone && !pwrite;
  endsequence

  direct_follow_a: assert property (modeLowStep |=> att1Ctrl == $past(pins.dir1)
    && att2Ctrl == $past(pins.dir2))
    else $error("direct mode not followed");

  pin_drive_a: assert property (ce |=> direct_weight_inputs1_oe == {5{$past(pins.mode)}}
    && (!$past(pins.mode) || direct_weight_inputs1_out == att1Ctrl))
    else $error("direct pins not driven with applied levels");

  pin_drive2_a: assert property (ce |=> direct_weight_inputs2_oe == {5{$past(pins.mode)}}
    && (!$past(pins.mode) || direct_weight_inputs2_out == att2Ctrl))
    else $error("second direct pins not driven with applied levels");

  ce_freeze_a: assert property (!ce |=> $stable(att1Ctrl) && $stable(att2Ctrl)
    && $stable(word) && $stable(pins))
    else $error("state moved while clock enable low");

  att1_first_a: assert property (modeHighStep ##0 pins.sel1 == 2'b00
    |=> att1Ctrl == $past(word[12:8]))
    else $error("attenuator one state one wrong");

  att1_select_a: assert property (modeHighStep ##0 pins.sel1 == 2'b01
    |=> att1Ctrl == $past(word[17:13]))
    else $error("attenuator one low pin select wrong");

  att1_third_a: assert property (modeHighStep ##0 pins.sel1 == 2'b10
    |=> att1Ctrl == $past(word[22:18]))
    else $error("attenuator one state three wrong");

  att1_bank_a: assert property (modeHighStep ##0 pins.sel1 == 2'b11
    |=> att1Ctrl == $past(word[27:23]))
    else $error("attenuator one state four wrong");

  att2_select_a: assert property (modeHighStep ##0 pins.sel2 == 2'b10
    |=> att2Ctrl == $past(word[50:46]))
    else $error("attenuator two high pin select wrong");

  att2_bank_a: assert property (modeHighStep ##0 pins.sel2 == 2'b00
    |=> att2Ctrl == $past(word[40:36]))
    else $error("attenuator two state one wrong");

  att2_second_a: assert property (modeHighStep ##0 pins.sel2 == 2'b01
    |=> att2Ctrl == $past(word[45:41]))
    else $error("attenuator two state two wrong");

  att2_fourth_a: assert property (modeHighStep ##0 pins.sel2 == 2'b11
    |=> att2Ctrl == $past(word[55:51]))
    else $error("attenuator two state four wrong");

  word_reserved_a: assert property (word[7:0] == 8'h00 && word[35:28] == 8'h00)
    else $error("reserved word bits held nonzero");

  apb_wait_a: assert property (apbSetup ##1 apbFirstAccess
    |-> !pready ##1 (!access || pready))
    else $error("apb wait state wrong");

  word_lo_write_a: assert property (ce && pready && pwrite && hitLo && pstrb == 4'hF
    |=> word[27:8] == $past(pwdata[27:8]))
    else $error("low word fields not stored");

  word_hi_write_a: assert property (ce && pready && pwrite && hitHi && pstrb == 4'hF
    |=> word[55:36] == $past(pwdata[23:4]))
    else $error("high word fields not stored");

  read_lo_a: assert property (firstRead ##0 hitLo
    |=> prdata == {4'h0, $past(word[27:8]), 8'h00})
    else $error("low word read view wrong");

  status_read_a: assert property (firstRead ##0 hitSt
    |=> prdata == {15'h0000, $past(pins.mode), 3'h0, $past(att2Ctrl), 3'h0, $past(att1Ctrl)})
    else $error("status read view wrong");

  unmapped_err_a: assert property (ce && access && !waitDone && !(hitLo || hitHi || hitSt)
    |=> pslverr && prdata == 32'h00000000 ##1 $stable(word))
    else $error("unmapped access not refused");

endmodule // dasc_top

`default_nettype wire

// [testbench/dasc_ctrl_model.sv]
// gain controller model driving mode, select and direct pins
`timescale 1ns/10ps
`default_nettype none

module dasc_ctrl_model (
  // clock
  input  wire logic               clk,
  // requested pin levels
  input  wire logic               mode,
  input  wire logic [1:0]         sel1,
  input  wire logic [1:0]         sel2,
  input  wire logic [4:0]         want1,
  input  wire logic [4:0]         want2,
  // device side of direct pins
  input  wire logic [4:0]         devOut1,
  input  wire logic [4:0]         devOe1,
  input  wire logic [4:0]         devOut2,
  input  wire logic [4:0]         devOe2,
  // resolved pins
  output var  dasc_pkg::dasc_pins_t pins
);
  logic [4:0] last1;
  logic [4:0] last2;

  function automatic logic [4:0] lvl(input logic [4:0] o, input logic [4:0] oe, input logic [4:0] w,
                                      input logic [4:0] last, input logic m);
    for (int i = 0; i < 5; i++) begin
      lvl[i] = oe[i] ? o[i] : (!m ? w[i] : ~last[i]);
    end
  endfunction

  // ==========================================================
  // pin resolution
  // pins released in stored mode
  always_comb begin
    pins.mode = mode;
    pins.sel1 = sel1;
    pins.sel2 = sel2;
    pins.dir1 = lvl(devOut1, devOe1, want1, last1, mode);
    pins.dir2 = lvl(devOut2, devOe2, want2, last2, mode);
  end

  always_ff @(posedge clk) begin
    last1 <= pins.dir1;
    last2 <= pins.dir2;
  end
endmodule // dasc_ctrl_model
`default_nettype wire

// [testbench/tb_dual_attenuator_state_control.sv]
// testbench for the dual attenuator state control
`timescale 1ns/10ps
`default_nettype none

module tb_dual_attenuator_state_control;
  logic                 clk;
  logic                 reset;
  logic                 ce;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic                 pready;
  logic                 pslverr;
  logic                 mode;
  logic                 err;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic [31:0]          rd;
  logic [1:0]           sel1;
  logic [1:0]           sel2;
  logic [4:0]           want1;
  logic [4:0]           want2;
  logic [4:0]           out1;
  logic [4:0]           oe1;
  logic [4:0]           out2;
  logic [4:0]           oe2;
  logic [4:0]           att1Ctrl;
  logic [4:0]           att2Ctrl;
  logic [4:0]           st1 [4];
  logic [4:0]           st2 [4];
  logic [55:0]          word;
  dasc_pkg::dasc_pins_t pins;
  int                   failures;
  int                   compares;
  int                   cycles = 0;

  dasc_top u_dasc_top (.clk(clk), .reset(reset), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .source_mode_select(pins.mode), .att1_state_sel_low(pins.sel1[0]), .att1_state_sel_high(pins.sel1[1]),
    .att2_state_sel_low(pins.sel2[0]), .att2_state_sel_high(pins.sel2[1]),
    .direct_weight_inputs1_in(pins.dir1), .direct_weight_inputs1_out(out1), .direct_weight_inputs1_oe(oe1),
    .direct_weight_inputs2_in(pins.dir2), .direct_weight_inputs2_out(out2), .direct_weight_inputs2_oe(oe2),
    .att1Ctrl(att1Ctrl), .att2Ctrl(att2Ctrl));

  dasc_ctrl_model u_dasc_ctrl_model (.clk(clk), .mode(mode), .sel1(sel1), .sel2(sel2), .want1(want1),
    .want2(want2), .devOut1(out1), .devOe1(oe1), .devOut2(out2), .devOe2(oe2), .pins(pins));

  // ==========================================================
  // clock and timeout
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      results();
    end
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [55:0] mkWord();
    logic [55:0] w;
    w = '0;
    for (int i = 0; i < 4; i++) begin
      w[8 + 5*i +: 5] = st1[i];
      w[36 + 5*i +: 5] = st2[i];
    end
    mkWord = w;
  endfunction

  task automatic results();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, mode, ce} = 5'h01;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    {sel1, sel2, want1, want2} = 14'h0000;
    failures = 0;
    compares = 0;
    st1 = '{5'h03, 5'h15, 5'h0A, 5'h11};
    st2 = '{5'h0C, 5'h19, 5'h07, 5'h1E};
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(8'h04, 1'b0, 32'h0, rd, err);
    chk(rd, 32'h0);
    for (int i = 0; i < 5; i++) begin
      want1 <= 5'h01 << i;
      want2 <= ~(5'h01 << i);
      repeat (8) @(posedge clk);
      chk(att1Ctrl, want1);
      chk(att2Ctrl, want2);
      chk(oe1, 5'h00);
      chk(oe2, 5'h00);
    end
    word = mkWord();
    apb(8'h00, 1'b1, word[31:0], rd, err);
    apb(8'h04, 1'b1, {8'h00, word[55:32]}, rd, err);
    apb(8'h00, 1'b0, 32'h0, rd, err);
    chk(rd, word[31:0]);
    apb(8'h04, 1'b0, 32'h0, rd, err);
    chk(rd, {8'h00, word[55:32]});
    mode <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sel1 <= 2'(i);
      sel2 <= 2'(3 - i);
      repeat (8) @(posedge clk);
      chk(att1Ctrl, st1[i]);
      chk(att2Ctrl, st2[3 - i]);
      chk(out1, st1[i]);
      chk(out2, st2[3 - i]);
      chk(oe2, 5'h1F);
      chk(oe1, 5'h1F);
    end
    apb(8'h08, 1'b0, 32'h0, rd, err);
    chk(rd, {15'h0, 1'b1, 3'h0, st2[0], 3'h0, st1[3]});
    apb(8'h0C, 1'b0, 32'h0, rd, err);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    mode <= 1'b0;
    want1 <= 5'h15;
    repeat (12) @(posedge clk);
    chk(att1Ctrl, 5'h15);
    chk(oe1, 5'h00);
    ce <= 1'b0;
    want1 <= 5'h0A;
    repeat (12) @(posedge clk);
    chk(att1Ctrl, 5'h15);
    ce <= 1'b1;
    repeat (12) @(posedge clk);
    chk(att1Ctrl, 5'h0A);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    apb(8'h04, 1'b0, 32'h0, rd, err);
    chk(rd, 32'h0);
    results();
  end
endmodule // tb_dual_attenuator_state_control
`default_nettype wire
